//--- host_port_defines.svh
// constants for the host parallel port of the uart
// assumes inclusion from the package and the port modules only
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define HP_ADDR_W 3
`define HP_DATA_W 8
`define HP_NUM_REGS 8
`define HP_SYNC_STAGES 2
`define HP_REG_RST 8'h00
`define HP_SEL_STROBES 1'b1
`define HP_SEL_DIRLINE 1'b0
`define HP_DIR_READ 1'b1
`define HP_DIR_WRITE 1'b0
`endif

//--- host_port_pkg.sv
// types for the host parallel port
// assumes host_port_defines.svh is on the include path
`include "host_port_defines.svh"
package host_port_pkg;
   typedef logic [`HP_ADDR_W-1:0] reg_sel_t;
   typedef logic [`HP_DATA_W-1:0] byte_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } access_state_t;
endpackage : host_port_pkg

//--- pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to i_clk
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("pin_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : pin_sync

//--- uart_host_bus_port.sv
// host parallel port of a single-channel uart: strobe or direction-line bus styles, muxed mode pin reuse
// assumes host pins are asynchronous to I_CLK_SYS and the host holds address and data across each strobe
// Function
// - select pin high gives separate active-low read and write strobes.
// - select pin low gives one direction line instead of two strobes.
// - select pin picks style only when muxed enable low; else sleep input.
// - three register-select lines address the internal register each access.
// - in muxed mode, select line one becomes active-low half-duplex enable.
// - read strobe fall drives addressed byte on bus; host samples at rise.
// - write strobe fall starts write; rise stores bus byte in register.
// - in direction-line mode, write strobe pin is direction: high read, low write.
// - eight-bit two-way data bus carries bytes; addresses always come from the select lines.
`timescale 1ns/10ps
`include "host_port_defines.svh"
module uart_host_bus_port #(
   parameter int ADDR_W = `HP_ADDR_W,
   parameter int DATA_W = `HP_DATA_W
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_MUXED_BUS_ENABLE,
   input wire logic I_BUS_TYPE_SEL,
   input wire logic I_CHIP_SELECT_N,
   input wire logic I_READ_STROBE_N,
   input wire logic I_WRITE_STROBE_N,
   input wire logic [ADDR_W-1:0] I_REGISTER_SELECT,
   input wire logic [DATA_W-1:0] I_HOST_DATA_BUS,
   output logic [DATA_W-1:0] O_HOST_DATA_BUS,
   output logic O_HOST_DATA_BUS_OE,
   output logic O_SLEEP_POWERDOWN_INPUT,
   output logic O_HALFDUPLEX_DIR_ENABLE_N,
   output logic O_STROBE_MODE,
   output logic [ADDR_W-1:0] O_ACCESS_ADDR,
   output logic O_READ_PULSE,
   output logic O_WRITE_PULSE,
   output logic [DATA_W-1:0] O_WRITE_DATA
);
   import host_port_pkg::*;

   localparam int NREG = 1 << ADDR_W;

   initial
   begin
      if (ADDR_W != `HP_ADDR_W || DATA_W != `HP_DATA_W)
      begin
         $error("uart_host_bus_port: only 3 select lines and 8 data lines are served");
      end
   end

   // all host pins pass two flops before any logic reads them
   localparam int SW = 5 + ADDR_W + DATA_W;
   logic [SW-1:0] pins_s;
   logic mux_s;
   logic sel_s;
   logic cs_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;

   pin_sync #(
      .WIDTH(SW),
      // select pin clears to the strobe style so the mode output does not dip after reset
      .RST_VAL({1'b0, `HP_SEL_STROBES, 3'b111, {(ADDR_W + DATA_W){1'b0}}})
   ) u_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_async({I_MUXED_BUS_ENABLE, I_BUS_TYPE_SEL, I_CHIP_SELECT_N, I_READ_STROBE_N,
         I_WRITE_STROBE_N, I_REGISTER_SELECT, I_HOST_DATA_BUS}),
      .o_sync(pins_s)
   );

   assign {mux_s, sel_s, cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pins_s;

   // mode follows the select pin only outside muxed mode
   logic strobe_mode;
   assign strobe_mode = !mux_s && (sel_s == `HP_SEL_STROBES);

   // previous samples for edge detection
   logic rd_n_q;
   logic wr_n_q;
   logic cs_n_q;
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         cs_n_q <= 1'b1;
      end
      else
      begin
         rd_n_q <= rd_n_s;
         wr_n_q <= wr_n_s;
         cs_n_q <= cs_n_s;
      end
   end

   // in direction-line mode the read strobe pin acts as the data strobe, qualified by chip select
   logic strb_n;
   logic strb_n_prev;
   assign strb_n = strobe_mode ? 1'b1 : (rd_n_s | cs_n_s);
   assign strb_n_prev = strobe_mode ? 1'b1 : (rd_n_q | cs_n_q);

   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;
   logic dl_fall;
   logic dl_rise;
   assign rd_fall = strobe_mode && rd_n_q && !rd_n_s && !cs_n_s;
   assign rd_rise = !rd_n_q && rd_n_s;
   assign wr_fall = strobe_mode && wr_n_q && !wr_n_s && !cs_n_s;
   assign wr_rise = !wr_n_q && wr_n_s;
   assign dl_fall = strb_n_prev && !strb_n;
   assign dl_rise = !strb_n_prev && strb_n;

   // register store; the uart core behind it is outside this block
   byte_t regs_q [NREG];
   access_state_t state_q;
   reg_sel_t addr_q;
   byte_t rdata_q;
   logic oe_q;

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         state_q <= ST_IDLE;
         addr_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (rd_fall || (dl_fall && wr_n_s == `HP_DIR_READ))
               begin
                  state_q <= ST_READ;
                  addr_q <= addr_s;
               end
               else if (wr_fall || (dl_fall && wr_n_s == `HP_DIR_WRITE))
               begin
                  state_q <= ST_WRITE;
                  addr_q <= addr_s;
               end
            end
            ST_READ:
            begin
               if (strobe_mode ? rd_rise : dl_rise)
               begin
                  state_q <= ST_IDLE;
               end
            end
            ST_WRITE:
            begin
               if (strobe_mode ? wr_rise : dl_rise)
               begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // write lands at the strobe's rising edge; data sampled while the strobe was still low
   logic wr_done;
   assign wr_done = (state_q == ST_WRITE) && (strobe_mode ? wr_rise : dl_rise);

   byte_t wdata_q;
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         wdata_q <= `HP_REG_RST;
      end
      else if (state_q == ST_WRITE && !wr_done)
      begin
         wdata_q <= data_s;
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         for (int i = 0; i < NREG; i++)
         begin
            regs_q[i] <= `HP_REG_RST;
         end
      end
      else if (wr_done)
      begin
         regs_q[addr_q] <= wdata_q;
      end
   end

   // read data held stable for the whole strobe low time
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         rdata_q <= `HP_REG_RST;
         oe_q <= 1'b0;
      end
      else if (state_q == ST_IDLE && (rd_fall || (dl_fall && wr_n_s == `HP_DIR_READ)))
      begin
         rdata_q <= regs_q[addr_s];
         oe_q <= 1'b1;
      end
      else if (state_q == ST_READ && (strobe_mode ? rd_rise : dl_rise))
      begin
         oe_q <= 1'b0;
      end
   end

   // one-cycle access pulses toward the uart core
   logic rd_pulse_q;
   logic wr_pulse_q;
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         rd_pulse_q <= 1'b0;
         wr_pulse_q <= 1'b0;
      end
      else
      begin
         rd_pulse_q <= (state_q == ST_IDLE) && (rd_fall || (dl_fall && wr_n_s == `HP_DIR_READ));
         wr_pulse_q <= wr_done;
      end
   end

   // muxed-mode pin reuse; levels are already synchronised
   logic sleep_q;
   logic hd_en_n_q;
   logic strobe_mode_q;
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_N)
      begin
         sleep_q <= 1'b0;
         hd_en_n_q <= 1'b1;
         strobe_mode_q <= `HP_SEL_STROBES;
      end
      else
      begin
         sleep_q <= mux_s && sel_s;
         hd_en_n_q <= mux_s ? addr_s[1] : 1'b1;
         strobe_mode_q <= strobe_mode;
      end
   end

   assign O_HOST_DATA_BUS = rdata_q;
   assign O_HOST_DATA_BUS_OE = oe_q;
   assign O_SLEEP_POWERDOWN_INPUT = sleep_q;
   assign O_HALFDUPLEX_DIR_ENABLE_N = hd_en_n_q;
   assign O_STROBE_MODE = strobe_mode_q;
   assign O_ACCESS_ADDR = addr_q;
   assign O_READ_PULSE = rd_pulse_q;
   assign O_WRITE_PULSE = wr_pulse_q;
   assign O_WRITE_DATA = wdata_q;
endmodule : uart_host_bus_port

//--- uart_host_bus_port_chk.sv
// timing checks on the host port pins of uart_host_bus_port
// assumes pins change away from the rising edge of I_CLK_SYS
`timescale 1ns/10ps
module uart_host_bus_port_chk
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_MUXED_BUS_ENABLE,
   input wire logic I_BUS_TYPE_SEL,
   input wire logic I_CHIP_SELECT_N,
   input wire logic I_READ_STROBE_N,
   input wire logic I_WRITE_STROBE_N,
   input wire logic [2:0] I_REGISTER_SELECT,
   input wire logic [7:0] I_HOST_DATA_BUS,
   input wire logic [7:0] O_HOST_DATA_BUS,
   input wire logic O_HOST_DATA_BUS_OE,
   input wire logic O_SLEEP_POWERDOWN_INPUT,
   input wire logic O_HALFDUPLEX_DIR_ENABLE_N,
   input wire logic O_STROBE_MODE,
   input wire logic [2:0] O_ACCESS_ADDR,
   input wire logic O_READ_PULSE,
   input wire logic O_WRITE_PULSE,
   input wire logic [7:0] O_WRITE_DATA
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);
   // direction-line reads also start on the read pin fall
   sequence rd_start;
      $fell(I_READ_STROBE_N) && !I_CHIP_SELECT_N && I_WRITE_STROBE_N;
   endsequence
   sequence wr_end;
      $rose(I_WRITE_STROBE_N) && !I_CHIP_SELECT_N && O_STROBE_MODE;
   endsequence
   a_strobe_style: assert property ((!I_MUXED_BUS_ENABLE && I_BUS_TYPE_SEL) [*4] |-> O_STROBE_MODE)
      else $error("strobe style missing");
   a_dirline_style: assert property ((!I_MUXED_BUS_ENABLE && !I_BUS_TYPE_SEL) [*4] |-> !O_STROBE_MODE)
      else $error("direction style missing");
   a_sleep_pin: assert property ((I_MUXED_BUS_ENABLE && I_BUS_TYPE_SEL) [*4] |-> O_SLEEP_POWERDOWN_INPUT)
      else $error("sleep input not passed");
   a_halfduplex_en: assert property ((I_MUXED_BUS_ENABLE && !I_REGISTER_SELECT[1]) [*4]
      |-> !O_HALFDUPLEX_DIR_ENABLE_N)
      else $error("half duplex enable missing");
   a_read_answer: assert property (rd_start |-> ##[2:5] (O_READ_PULSE && O_HOST_DATA_BUS_OE))
      else $error("read not answered");
   a_read_release: assert property ($rose(I_READ_STROBE_N) |-> ##[2:5] !O_HOST_DATA_BUS_OE)
      else $error("bus not released");
   a_write_commit: assert property (wr_end |-> ##[2:5] O_WRITE_PULSE)
      else $error("write not committed");
   a_write_byte: assert property (O_WRITE_PULSE |-> O_WRITE_DATA == $past(I_HOST_DATA_BUS, 5))
      else $error("write byte wrong");
endmodule : uart_host_bus_port_chk
bind uart_host_bus_port uart_host_bus_port_chk u_chk (.*);

//--- host_bus_model.sv
// host bus master: drives select, strobes, address and data on falling edges
// assumes one caller at a time; hold is the strobe low time in cycles
`timescale 1ns/10ps
module host_bus_model
(
   input wire logic i_clk,
   input wire host_port_pkg::byte_t i_data,
   input wire logic i_oe,
   output logic o_cs_n = 1'b1,
   output logic o_rd_n = 1'b1,
   output logic o_wr_n = 1'b1,
   output host_port_pkg::reg_sel_t o_addr = 3'h0,
   output host_port_pkg::byte_t o_data = 8'h00
);
   import host_port_pkg::*;
   task automatic xfer(input bit strb, input bit cs, input bit rd, input reg_sel_t a, input byte_t d,
      input int hold, output byte_t q, output logic oe);
      @(negedge i_clk);
      o_cs_n = !cs;
      o_addr = a;
      o_data = d;
      if (!strb)
         o_wr_n = rd;
      @(negedge i_clk);
      if (strb && !rd)
         o_wr_n = 1'b0;
      else
         o_rd_n = 1'b0;
      repeat (hold) @(negedge i_clk);
      q = i_data;
      oe = i_oe;
      o_rd_n = 1'b1;
      if (strb)
         o_wr_n = 1'b1;
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_wr_n = 1'b1;
      // held data gone: show its inverse
      o_data = ~o_data;
   endtask : xfer
endmodule : host_bus_model

//--- testbench.sv
// self-checking bench for uart_host_bus_port with a byte-array register model
// assumes host_bus_model and the bound checker are compiled with it
`timescale 1ns/10ps
module testbench;
   import host_port_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, muxed = 1'b0, sel = 1'b1, qoe;
   logic cs_n, rd_n, wr_n, oe, hd_n, sleep, mode;
   logic rdp, wrp;
   int n_rd = 0, n_wr = 0, e_rd = 0, e_wr = 0;
   reg_sel_t addr, acc_addr;
   byte_t din, dout, wdata, q, d;
   byte_t m [8];
   int err_total = 0, comparisons = 0, cyc = 0;
   initial forever #12.5 clk = ~clk;
   uart_host_bus_port u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_MUXED_BUS_ENABLE(muxed),
      .I_BUS_TYPE_SEL(sel), .I_CHIP_SELECT_N(cs_n), .I_READ_STROBE_N(rd_n), .I_WRITE_STROBE_N(wr_n),
      .I_REGISTER_SELECT(addr), .I_HOST_DATA_BUS(din), .O_HOST_DATA_BUS(dout), .O_HOST_DATA_BUS_OE(oe),
      .O_SLEEP_POWERDOWN_INPUT(sleep), .O_HALFDUPLEX_DIR_ENABLE_N(hd_n), .O_STROBE_MODE(mode),
      .O_ACCESS_ADDR(acc_addr), .O_READ_PULSE(rdp), .O_WRITE_PULSE(wrp), .O_WRITE_DATA(wdata));
   host_bus_model u_host (.i_clk(clk), .i_data(dout), .i_oe(oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_addr(addr), .o_data(din));
   task automatic chk(input string n, input byte_t e, input byte_t g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic acc(input bit strb, input bit cs, input bit rd, input reg_sel_t a, input int hold);
      d = byte_t'($urandom);
      u_host.xfer(strb, cs, rd, a, d, hold, q, qoe);
      repeat (6) @(negedge clk);
      if (rd)
      begin
         chk("read data", m[a], q);
         chk("bus drive", 8'h01, {7'h00, qoe});
      end
      else if (cs)
      begin
         m[a] = d;
         chk("write data", d, wdata);
      end
      if (cs)
      begin
         chk("access addr", {5'h00, a}, {5'h00, acc_addr});
         if (rd)
            e_rd++;
         else
            e_wr++;
      end
   endtask : acc
   // pulses last one cycle, so each is seen at exactly one falling edge
   always @(negedge clk)
   begin
      if (rdp === 1'b1)
         n_rd++;
      if (wrp === 1'b1)
         n_wr++;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         test_done;
      end
   end
   initial
   begin
      void'($urandom(37061));
      for (int i = 0; i < 8; i++)
         m[i] = 8'h00;
      // synchronisers clear under reset, so two edges suffice
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("idle drive", 8'h00, {7'h00, oe});
      chk("strobe mode", 8'h01, {7'h00, mode});
      chk("half duplex", 8'h01, {7'h00, hd_n});
      for (int i = 0; i < 24; i++)
         acc(1'b1, 1'b1, i / 8 != 1, reg_sel_t'(i), 5 + 4 * (i % 2));
      acc(1'b1, 1'b0, 1'b0, 3'h2, 5);
      acc(1'b1, 1'b1, 1'b1, 3'h2, 5);
      sel = 1'b0;
      repeat (5) @(negedge clk);
      chk("strobe mode", 8'h00, {7'h00, mode});
      for (int i = 0; i < 16; i++)
         acc(1'b0, 1'b1, i[0], reg_sel_t'($urandom), 5);
      // leaves select bit one low for the muxed-mode checks
      acc(1'b0, 1'b1, 1'b1, 3'h5, 5);
      chk("half duplex", 8'h01, {7'h00, hd_n});
      muxed = 1'b1;
      sel = 1'b1;
      repeat (5) @(negedge clk);
      chk("sleep", 8'h01, {7'h00, sleep});
      chk("half duplex", 8'h00, {7'h00, hd_n});
      sel = 1'b0;
      repeat (5) @(negedge clk);
      chk("sleep", 8'h00, {7'h00, sleep});
      chk("read pulses", byte_t'(e_rd), byte_t'(n_rd));
      chk("write pulses", byte_t'(e_wr), byte_t'(n_wr));
      test_done;
   end
endmodule : testbench
